// File: rtl/adc_cfg_pkg.sv
// Purpose: shared constants for the converter output and config block
// Assumes: one sample per two clk_sys cycles, offset binary core code
// Notes: serial and bus register maps live here
// Functional notes
// (R01) strap mode: format pin picks output coding
// (R02) serial mode offers binary, twos, gray codings
// (R03) full scale codes fixed per coding
// (R04) range flag shares data pipeline latency
// (R05) range flag follows converter range per sample
// (R06) capture logic decodes under/over from flag+MSB
// (R07) disable pin low enables data drivers
// (R08) data appears twelve sample cycles later
// (R09) capture clock rising mid-data unless inverted
// (R10) shift clock, data line, active-low select
// (R11) frame starts at first rise after select falls
// (R12) select held low streams bytes
// (R13) select high between bytes stalls, keeps place; with word length 11 the code ends the frame there instead
// (R14) select high floats data pin, strap functions; code keeps straps only until first select fall or bus config write
// (R15) 16-bit instruction then 8-bit data words
// (R16) read bit turns data line around
// (R17) clock, select inputs; data pin bidirectional
// (R18) msb first at reset, lsb first selectable
// (R19) unused port: clock/data pins read as straps
// (R20) strap levels: low binary/off, high twos/on
// (R21) word length 00..10 one-three bytes, 11 stream
// (R22) sample on rise, drive after fall
package adc_cfg_pkg;
    localparam int DATA_W = 14;
    localparam int PIPE_DEPTH = 12;
    localparam int INSTR_LAST = 15;
    localparam int BYTE_LAST = 7;
    // output codings and stream word length
    localparam logic [1:0] FMT_BINARY = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    // serial register addresses
    localparam logic [12:0] SER_PORT_CFG = 13'h0000;
    localparam logic [12:0] SER_CLOCK = 13'h0009;
    localparam logic [12:0] SER_OUT_MODE = 13'h0014;
    localparam logic [12:0] SER_OUT_PHASE = 13'h0016;
    localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
    localparam int PORT_LSB_HI = 6;
    localparam int PORT_LSB_LO = 1;
    // bus register byte addresses
    localparam logic [7:0] AXI_CFG = 8'h00;
    localparam logic [7:0] AXI_STATUS = 8'h04;
    localparam logic [7:0] AXI_SAMPLE = 8'h08;
    localparam int CFG_FMT_LO = 0;
    localparam int CFG_INV = 2;
    localparam int CFG_DCS = 3;
    localparam int CFG_LSB = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // values after reset
    localparam logic [1:0] FMT_RST = 2'h0;
    localparam logic DCS_RST = 1'b1;
    localparam logic INV_RST = 1'b0;
    localparam logic LSB_RST = 1'b0;
    typedef enum logic [1:0] {SER_IDLE, SER_INSTR, SER_DATA, SER_DONE}
        ser_state_t;
endpackage

// File: rtl/pin_sync.sv
// Purpose: two-flop synchroniser for pins
// Assumes: inputs asynchronous to clk_sys
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] pin_s
);
    logic [W-1:0] meta;

    // two stage capture
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            pin_s <= '0;
        end
        else
        begin
            meta <= pin;
            pin_s <= meta;
        end
    end
endmodule

// File: rtl/code_formatter.sv
// Purpose: recode offset binary sample into selected coding
// Assumes: raw code is offset binary
// Notes: unused coding value falls back to binary
`timescale 1ns/1ps
module code_formatter (
    input wire logic [13:0] raw,
    input wire logic [1:0] fmt,
    output logic [13:0] coded
);
    logic [13:0] twos;
    logic [13:0] gray;

    // twos flips msb; gray built on twos, top pair swapped
    always_comb
    begin
        twos = {~raw[13], raw[12:0]}; // R02
        gray = twos ^ {1'b0, twos[13:1]};
        gray = {gray[12], gray[13], gray[11:0]}; // R03
        case (fmt)
            adc_cfg_pkg::FMT_TWOS: coded = twos;
            adc_cfg_pkg::FMT_GRAY: coded = gray;
            default: coded = raw;
        endcase
    end
endmodule

// File: rtl/adc_output_and_serial_config.sv
// Purpose: sample output path, serial config port, strap mode, bus regs
// Assumes: converter core delivers code and range flag per conversion
// Notes: conversion every second clk_sys edge
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module adc_output_and_serial_config (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [13:0] conv_code,
    input wire logic conv_out_of_range,
    input wire logic output_drive_disable_n,
    output logic [13:0] data_out,
    output logic range_flag,
    output logic data_oe,
    output logic data_capture_clock,
    input wire logic serial_clock_format_pin,
    input wire logic port_select_n,
    input wire logic serial_data_stabilizer_pin_in,
    output logic serial_data_stabilizer_pin_out,
    output logic serial_data_stabilizer_pin_oe,
    output logic duty_cycle_stabilizer,
    output logic strap_mode,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int LAST = adc_cfg_pkg::PIPE_DEPTH - 1;

    logic [3:0] pin_s;
    logic drv_dis_s, sclk_s, sdi_s, cs_s;
    logic conv_phase, next_conv_phase, advance;
    logic [14:0] pipe [adc_cfg_pkg::PIPE_DEPTH];
    logic [14:0] next_pipe [adc_cfg_pkg::PIPE_DEPTH];
    logic [13:0] coded, next_data_out;
    logic next_range_flag, next_data_oe, next_dcc;
    logic [1:0] fmt_sel, next_fmt_sel, eff_fmt;
    logic invert, next_invert, dcs_en, next_dcs_en;
    logic lsb_first, next_lsb_first, next_strap_mode, next_dcs_out;
    adc_cfg_pkg::ser_state_t ser_state, next_ser_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [15:0] instr, next_instr, instr_word;
    logic [7:0] rx_byte, next_rx_byte, rx_word, rd_byte;
    logic [12:0] ser_addr, next_ser_addr;
    logic [1:0] byte_cnt, next_byte_cnt, len, next_len;
    logic rd, next_rd, next_sdo, next_sdo_oe;
    logic sclk_d, cs_d, sclk_rise, sclk_fall, cs_fall;
    logic ser_wr;
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data, next_rdata;
    logic w_strb0, next_w_strb0, axi_wr;
    logic next_awready, next_wready, next_bvalid, next_arready;
    logic next_rvalid;
    logic [1:0] next_bresp, next_rresp;

    // pins cross into clk_sys
    pin_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin({output_drive_disable_n, serial_clock_format_pin,
              serial_data_stabilizer_pin_in, port_select_n}),
        .pin_s(pin_s)
    );
    assign {drv_dis_s, sclk_s, sdi_s, cs_s} = pin_s;

    // edges of the serial pins
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign cs_fall = ~cs_s & cs_d;
    assign advance = ~conv_phase;

    // strap pins pick coding until serial port is first used or bus config register is first written
    assign eff_fmt = strap_mode ? (sclk_s ? adc_cfg_pkg::FMT_TWOS // R01 R20
                   : adc_cfg_pkg::FMT_BINARY) : fmt_sel; // R02

    // sample pipeline, one stage per conversion
    genvar gi;
    generate
        for (gi = 0; gi < adc_cfg_pkg::PIPE_DEPTH; gi++)
        begin : g_pipe
            if (gi == 0)
            begin : g_head
                assign next_pipe[gi] = advance ?
                    {conv_out_of_range, conv_code} : pipe[gi]; // R04 R05
            end
            else
            begin : g_body
                assign next_pipe[gi] = advance ? pipe[gi-1] : pipe[gi];
            end
        end
    endgenerate

    code_formatter u_fmt (
        .raw(pipe[LAST][13:0]),
        .fmt(eff_fmt),
        .coded(coded)
    );

    // output stage next values
    always_comb
    begin
        next_conv_phase = ~conv_phase;
        next_data_out = data_out;
        next_range_flag = range_flag;
        if (advance)
        begin
            next_data_out = coded; // R08
            next_range_flag = pipe[LAST][14]; // R04
        end
        next_dcc = advance ? invert : ~invert; // R09
        next_data_oe = ~drv_dis_s; // R07
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_phase <= 1'b0;
            pipe <= '{default: 15'h0000};
            data_out <= 14'h0000;
            range_flag <= 1'b0;
            data_capture_clock <= 1'b0;
            data_oe <= 1'b0;
        end
        else
        begin
            conv_phase <= next_conv_phase;
            pipe <= next_pipe;
            data_out <= next_data_out;
            range_flag <= next_range_flag;
            data_capture_clock <= next_dcc;
            data_oe <= next_data_oe;
        end
    end

    // serial word assembly in either bit order
    always_comb
    begin
        instr_word = lsb_first ? {sdi_s, instr[15:1]} // R18
                   : {instr[14:0], sdi_s};
        rx_word = lsb_first ? {sdi_s, rx_byte[7:1]}
                : {rx_byte[6:0], sdi_s};
        case (ser_addr)
            adc_cfg_pkg::SER_PORT_CFG: rd_byte = adc_cfg_pkg::PORT_CFG_FIXED
                | ({7'h00, lsb_first} << adc_cfg_pkg::PORT_LSB_HI)
                | ({7'h00, lsb_first} << adc_cfg_pkg::PORT_LSB_LO);
            adc_cfg_pkg::SER_CLOCK: rd_byte = {7'h00, dcs_en};
            adc_cfg_pkg::SER_OUT_MODE: rd_byte = {6'h00, fmt_sel};
            adc_cfg_pkg::SER_OUT_PHASE: rd_byte = {7'h00, invert};
            default: rd_byte = 8'h00;
        endcase
    end

    // serial frame sequencing
    always_comb
    begin
        next_ser_state = ser_state;
        next_bit_cnt = bit_cnt;
        next_instr = instr;
        next_rx_byte = rx_byte;
        next_ser_addr = ser_addr;
        next_byte_cnt = byte_cnt;
        next_len = len;
        next_rd = rd;
        next_sdo = serial_data_stabilizer_pin_out;
        next_sdo_oe = 1'b0;
        ser_wr = 1'b0;
        case (ser_state)
            adc_cfg_pkg::SER_IDLE:
            begin
                if (cs_fall) // R10 R11
                begin
                    next_ser_state = adc_cfg_pkg::SER_INSTR;
                    next_bit_cnt = 4'h0;
                    next_byte_cnt = 2'h0;
                end
            end
            adc_cfg_pkg::SER_INSTR:
            begin
                if (sclk_rise && !cs_s) // R22
                begin
                    next_instr = instr_word;
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == 4'(adc_cfg_pkg::INSTR_LAST)) // R15
                    begin
                        next_ser_state = adc_cfg_pkg::SER_DATA;
                        next_bit_cnt = 4'h0;
                        next_rd = instr_word[15]; // R16
                        next_len = instr_word[14:13]; // R21
                        next_ser_addr = instr_word[12:0];
                    end
                end
            end
            adc_cfg_pkg::SER_DATA:
            begin
                if (cs_s)
                begin
                    // stream ends on select rise at a byte boundary
                    if (len == adc_cfg_pkg::LEN_STREAM && bit_cnt == 4'h0)
                        next_ser_state = adc_cfg_pkg::SER_IDLE; // R12
                end
                else
                begin
                    // drive readback after the falling edge only
                    next_sdo_oe = rd && (sclk_fall ||
                        serial_data_stabilizer_pin_oe); // R16 R17
                    if (rd && sclk_fall)
                        next_sdo = rd_byte[lsb_first ? bit_cnt[2:0]
                            : 3'(adc_cfg_pkg::BYTE_LAST) - bit_cnt[2:0]];
                    if (sclk_rise)
                    begin
                        next_rx_byte = rx_word;
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == 4'(adc_cfg_pkg::BYTE_LAST)) // R15
                        begin
                            ser_wr = ~rd;
                            next_bit_cnt = 4'h0;
                            next_ser_addr = ser_addr + 13'h0001;
                            next_byte_cnt = byte_cnt + 2'h1;
                            if (len != adc_cfg_pkg::LEN_STREAM &&
                                byte_cnt == len) // R21
                                next_ser_state = adc_cfg_pkg::SER_DONE;
                        end
                    end
                end
            end
            adc_cfg_pkg::SER_DONE:
            begin
                if (cs_s)
                    next_ser_state = adc_cfg_pkg::SER_IDLE;
            end
            default: next_ser_state = adc_cfg_pkg::SER_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser_state <= adc_cfg_pkg::SER_IDLE;
            bit_cnt <= 4'h0;
            instr <= 16'h0000;
            rx_byte <= 8'h00;
            ser_addr <= 13'h0000;
            byte_cnt <= 2'h0;
            len <= 2'h0;
            rd <= 1'b0;
            serial_data_stabilizer_pin_out <= 1'b0;
            serial_data_stabilizer_pin_oe <= 1'b0;
            sclk_d <= 1'b0;
            cs_d <= 1'b0; // synced select also reads 0, no false fall
        end
        else
        begin
            ser_state <= next_ser_state;
            bit_cnt <= next_bit_cnt;
            instr <= next_instr;
            rx_byte <= next_rx_byte;
            ser_addr <= next_ser_addr;
            byte_cnt <= next_byte_cnt;
            len <= next_len;
            rd <= next_rd;
            serial_data_stabilizer_pin_out <= next_sdo;
            serial_data_stabilizer_pin_oe <= next_sdo_oe; // R14
            sclk_d <= sclk_s;
            cs_d <= cs_s;
        end
    end

    // configuration: serial writes win over bus writes
    always_comb
    begin
        next_fmt_sel = fmt_sel;
        next_invert = invert;
        next_dcs_en = dcs_en;
        next_lsb_first = lsb_first;
        next_strap_mode = strap_mode;
        if (cs_fall || axi_wr)
            next_strap_mode = 1'b0; // R19
        if (axi_wr)
        begin
            next_fmt_sel = w_data[adc_cfg_pkg::CFG_FMT_LO +: 2];
            next_invert = w_data[adc_cfg_pkg::CFG_INV];
            next_dcs_en = w_data[adc_cfg_pkg::CFG_DCS];
            next_lsb_first = w_data[adc_cfg_pkg::CFG_LSB];
        end
        if (ser_wr)
        begin
            case (ser_addr)
                adc_cfg_pkg::SER_PORT_CFG: next_lsb_first = // R18
                    rx_word[adc_cfg_pkg::PORT_LSB_HI]
                    | rx_word[adc_cfg_pkg::PORT_LSB_LO];
                adc_cfg_pkg::SER_CLOCK: next_dcs_en = rx_word[0];
                adc_cfg_pkg::SER_OUT_MODE: next_fmt_sel = rx_word[1:0];
                adc_cfg_pkg::SER_OUT_PHASE: next_invert = rx_word[0];
                default: next_fmt_sel = fmt_sel;
            endcase
        end
        next_dcs_out = strap_mode ? sdi_s : dcs_en; // R20
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fmt_sel <= adc_cfg_pkg::FMT_RST;
            invert <= adc_cfg_pkg::INV_RST;
            dcs_en <= adc_cfg_pkg::DCS_RST;
            lsb_first <= adc_cfg_pkg::LSB_RST;
            strap_mode <= 1'b1;
            duty_cycle_stabilizer <= adc_cfg_pkg::DCS_RST;
        end
        else
        begin
            fmt_sel <= next_fmt_sel;
            invert <= next_invert;
            dcs_en <= next_dcs_en;
            lsb_first <= next_lsb_first;
            strap_mode <= next_strap_mode;
            duty_cycle_stabilizer <= next_dcs_out;
        end
    end

    // bus slave: one write and one read outstanding
    assign axi_wr = aw_got && w_got && !s_axi_bvalid && w_strb0 &&
                    aw_addr == adc_cfg_pkg::AXI_CFG;
    always_comb
    begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb0 = w_strb0;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_got = 1'b1;
            next_aw_addr = s_axi_awaddr;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_got = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb0 = s_axi_wstrb[0];
            next_wready = 1'b0;
        end
        if (aw_got && w_got && !s_axi_bvalid)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == adc_cfg_pkg::AXI_CFG ||
                aw_addr == adc_cfg_pkg::AXI_STATUS ||
                aw_addr == adc_cfg_pkg::AXI_SAMPLE) ?
                adc_cfg_pkg::RESP_OKAY : adc_cfg_pkg::RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = adc_cfg_pkg::RESP_OKAY;
            case (s_axi_araddr)
                adc_cfg_pkg::AXI_CFG: next_rdata = {27'h0, lsb_first,
                    dcs_en, invert, fmt_sel};
                adc_cfg_pkg::AXI_STATUS: next_rdata = {26'h0, strap_mode,
                    ser_state != adc_cfg_pkg::SER_IDLE, range_flag,
                    data_oe, eff_fmt};
                adc_cfg_pkg::AXI_SAMPLE: next_rdata = {18'h0, data_out};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = adc_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb0 <= next_w_strb0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // checks on output path and serial port
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence seq_frame_open;
        cs_fall && ser_state == adc_cfg_pkg::SER_IDLE;
    endsequence
    sequence seq_instr_end;
        ser_state == adc_cfg_pkg::SER_INSTR && sclk_rise && !cs_s
            && bit_cnt == 4'hf;
    endsequence

    AST_FLAG_LATENCY: assert property (advance && $past(rst_n, 25) // R04
        |-> ##25 range_flag == $past(conv_out_of_range, 25))
        else $error("range flag latency wrong");
    AST_DATA_LATENCY: assert property (advance && $past(rst_n, 25) // R08
        |-> ##25 ($past(eff_fmt) == adc_cfg_pkg::FMT_TWOS
        || $past(eff_fmt) == adc_cfg_pkg::FMT_GRAY
        || data_out == $past(conv_code, 25)))
        else $error("data latency wrong");
    AST_OE_FOLLOW: assert property (!output_drive_disable_n [*3] // R07
        |=> data_oe)
        else $error("drivers not enabled");
    AST_DCC_EDGE: assert property (advance // R09
        |=> data_capture_clock == $past(invert))
        else $error("capture clock phase wrong");
    AST_FRAME_START: assert property (seq_frame_open // R11
        |=> ser_state == adc_cfg_pkg::SER_INSTR && bit_cnt == 4'h0)
        else $error("frame did not open");
    AST_INSTR_LEN: assert property (seq_instr_end // R15
        |=> ser_state == adc_cfg_pkg::SER_DATA && bit_cnt == 4'h0)
        else $error("instruction length wrong");
    AST_PIN_FLOAT: assert property (cs_s // R14
        |=> !serial_data_stabilizer_pin_oe)
        else $error("data pin driven while deselected");
    AST_DRIVE_ON_FALL: assert property ($rose(serial_data_stabilizer_pin_oe) // R22
        |-> $past(sclk_fall) && rd)
        else $error("readback drive not after fall");
    AST_STALL_HOLD: assert property (cs_s && ser_state == adc_cfg_pkg::SER_DATA
        && len != adc_cfg_pkg::LEN_STREAM // R13
        |=> $stable(bit_cnt) && $stable(ser_addr))
        else $error("stall lost position");
endmodule

// File: verification/cfg_host.sv
// Purpose: host model of the three-wire config port
// Assumes: 64 ns shift clock, parked high outside frames
// Notes: a released data line toggles
`timescale 1ns/1ps
module cfg_host (
    output logic sclk,
    output logic sel_n,
    output logic sdio,
    input wire logic dev_out,
    input wire logic dev_oe
);
    logic hd = 1'b0, hoe = 1'b1, flip = 1'b0;
    // line level from both drivers
    assign sdio = dev_oe ? dev_out : hoe ? hd : flip;
    initial sclk = 1'b1;
    initial sel_n = 1'b1;
    // one frame: instruction, then one byte
    task automatic xfer(input logic [23:0] sh, output logic [7:0] rv);
        // pins move 2 ns off the clk_sys edges
        #2 sel_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            #32 sclk = 1'b0;
            // read bit is sent first in msb order, last in lsb order
            hoe = !((sh[23] || sh[8]) && i < 8);
            hd = sh[i];
            flip = ~flip;
            #32 sclk = 1'b1;
            rv[i % 8] = sdio;
            // stall between instruction and data
            if (i == 8)
            begin
                #32 sel_n = 1'b1;
                #64 sel_n = 1'b0;
            end
        end
        #32 sel_n = 1'b1;
        hoe = 1'b1;
        #30; // select stays high a while, return on a clk_sys edge
    endtask
endmodule

// File: verification/tb_adc_output_and_serial_config.sv
// Purpose: self-checking bench for output path and config port
// Assumes: conversion on every second clk_sys edge
// Notes: samples checked at the active capture clock edge
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_adc_output_and_serial_config;
    logic clk_sys = 1'b0, rst_n = 1'b0, output_drive_disable_n = 1'b0;
    logic [13:0] conv_code = 14'h0000, data_out;
    logic conv_out_of_range = 1'b0, range_flag, data_oe, data_capture_clock;
    logic serial_clock_format_pin, port_select_n, strap_mode;
    logic serial_data_stabilizer_pin_in, serial_data_stabilizer_pin_out;
    logic serial_data_stabilizer_pin_oe, duty_cycle_stabilizer;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rv;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h37;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic arm = 1'b0, inv = 1'b0, prev = 1'b0;
    logic [14:0] want, q[$];
    int miscompares = 0, cmp_count = 0, skip = 0, cycles = 0;
    adc_output_and_serial_config uut (.*);
    cfg_host host (.sclk(serial_clock_format_pin), .sel_n(port_select_n),
        .sdio(serial_data_stabilizer_pin_in),
        .dev_out(serial_data_stabilizer_pin_out),
        .dev_oe(serial_data_stabilizer_pin_oe));
    // system clock
    initial forever #4 clk_sys = ~clk_sys;
    // verdict and end of run
    task automatic end_of_test(input int bad);
        miscompares += bad;
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // run limit; oldest note checked at each active capture edge after the first 13
    always @(posedge clk_sys)
    begin
        prev <= data_capture_clock;
        cycles++;
        if (cycles == 4000) end_of_test(1);
        if (!arm) skip = 0;
        if (arm && data_capture_clock == !inv && prev == inv)
            skip = skip + 1;
        if (arm && data_capture_clock == !inv && prev == inv && skip > 13)
        begin
            want = q.pop_front();
            `CHK("sample", want, {range_flag, data_out})
        end
    end
    // one bus access, valids held until taken
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        `CHK("resp", er, wr ? s_axi_bresp : s_axi_rresp)
        if (!wr) `CHK("rdata", d, s_axi_rdata)
        @(posedge clk_sys);
    endtask
    // sixteen samples held two cycles each, expected codes noted
    task automatic feed(input logic [1:0] f);
        logic [13:0] r, t, g;
        logic o;
        arm <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            r = i == 0 ? 14'h0000 : i == 1 ? 14'h3fff : seed[13:0];
            t = {~r[13], r[12:0]};
            g = t ^ (t >> 1);
            conv_code <= r;
            // flag only with full-scale codes, so flag and msb decode
            o = i < 2;
            conv_out_of_range <= o;
            q.push_back({o, f == 2'h1 ? t :
                f == 2'h2 ? {g[12], g[13], g[11:0]} : r});
            repeat (2) @(posedge clk_sys);
        end
        repeat (26) @(posedge clk_sys);
        arm <= 1'b0;
    endtask
    // strap mode, bus setup, serial setup, output disable
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        feed(2'h1);
        `CHK("strap", 2'h2, {strap_mode, duty_cycle_stabilizer})
        `CHK("pin oe", 1'b0, serial_data_stabilizer_pin_oe)
        bus(1'b1, 8'h00, 32'h0000_000e, 2'h0);
        bus(1'b0, 8'h00, 32'h0000_000e, 2'h0);
        bus(1'b0, 8'h0c, 32'h0000_0000, 2'h2);
        inv = 1'b1;
        feed(2'h2);
        host.xfer(24'h001600, rv);
        host.xfer(24'h001403, rv);
        host.xfer(24'h801400, rv);
        `CHK("serial rd", 8'h03, rv)
        host.xfer(24'h800000, rv);
        `CHK("port cfg", 8'h18, rv)
        // lsb first: instruction and data bits go out reversed
        host.xfer(24'h000042, rv);
        host.xfer(24'h280100, rv);
        `CHK("lsb rd", 8'hc0, rv)
        inv = 1'b0;
        @(posedge clk_sys);
        feed(2'h0);
        `CHK("drive", 1'b1, data_oe)
        output_drive_disable_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("drive", 1'b0, data_oe)
        end_of_test(0);
    end
endmodule
